// ==== ldd_pkg.sv ====
// Package: constants and types for the lift drive input decoder
`default_nettype none
package ldd_pkg;
  // ----------------------------------------------------------------
  // Configuration presets
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_FREE  = 8'h00;
  localparam logic [7:0] CFG_P01   = 8'h01;
  localparam logic [7:0] CFG_P03   = 8'h03;
  localparam logic [7:0] CFG_P08   = 8'h08;
  localparam logic [7:0] CFG_P11   = 8'h11;
  localparam logic [7:0] CFG_P13   = 8'h13;
  localparam logic [7:0] CFG_P15   = 8'h15;
  localparam logic [7:0] CFG_P16   = 8'h16;
  localparam logic [7:0] CFG_P21   = 8'h21;
  localparam logic [7:0] CFG_P25   = 8'h25;
  localparam logic [7:0] CFG_P30   = 8'h30;
  // ----------------------------------------------------------------
  // Speed select codes (binary index of the output)
  // ----------------------------------------------------------------
  localparam logic [3:0] SPD_NONE  = 4'h0;
  localparam logic [3:0] SPD_ONE   = 4'h1;
  localparam logic [3:0] SPD_TWO   = 4'h2;
  localparam logic [3:0] SPD_THREE = 4'h3;
  localparam logic [3:0] SPD_FOUR  = 4'h4;
  localparam logic [3:0] SPD_FIVE  = 4'h5;
  localparam logic [3:0] SPD_SIX   = 4'h6;
  localparam logic [3:0] SPD_INTER = 4'h7;
  localparam logic [3:0] SPD_FREE1 = 4'h8;
  // ----------------------------------------------------------------
  // Sensor types
  // ----------------------------------------------------------------
  localparam logic [1:0] SENS_OFF    = 2'h0;
  localparam logic [1:0] SENS_PTC    = 2'h1;
  localparam logic [1:0] SENS_LINEAR = 2'h2;
  localparam logic [1:0] SENS_SWITCH = 2'h3;
  localparam int unsigned PTC_TRIP_OHM    = 3500;
  localparam int unsigned SHORT_LIMIT_OHM = 20;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned DEBOUNCE_US   = 10;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_US * CLK_MHZ;
  localparam logic [1:0] RST_TRAVEL     = 2'h0;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_TRAVEL = 3'b010,
    ST_LOCK   = 3'b100
  } ldd_state_type;
endpackage : ldd_pkg
`default_nettype wire

// ==== ldd_filter_if.sv ====
// Interface: raw and filtered digital inputs between decoder and filter
`default_nettype none
interface ldd_filter_if #(parameter int unsigned N = 8);
  logic [N-1:0] rawIn;
  logic [N-1:0] cleanIn;
  modport top (output rawIn, input cleanIn);
  modport filt (input rawIn, output cleanIn);
endinterface : ldd_filter_if
`default_nettype wire

// ==== ldd_input_filter.sv ====
// Module: per-input synchroniser and debounce filter
`default_nettype none
module ldd_input_filter #(
  parameter int unsigned N   = 8,
  parameter int unsigned CYC = ldd_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic   sys_clk,
  input wire logic   rst_b,
  input wire logic   clkEn,
  // Inputs
  ldd_filter_if.filt port
);
  localparam int unsigned CW = $clog2(CYC + 1);
  if (CYC < 1) begin : g_badCycles
    $error("debounce count must be at least one");
  end
  // ----------------------------------------------------------------
  // One filter per input
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_in
    logic          s1_r, s2_r, out_r, s1_nxt, s2_nxt, out_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    always_comb begin
      s1_nxt  = port.rawIn[i];
      s2_nxt  = s1_r;
      out_nxt = out_r;
      cnt_nxt = cnt_r;
      // Only a level stable for the full window is accepted
      if (s2_r == out_r) begin
        cnt_nxt = '0;
      end else if (cnt_r == CW'(CYC - 1)) begin
        out_nxt = s2_r;
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + CW'(1);
      end
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        s1_r  <= 1'b0;
        s2_r  <= 1'b0;
        out_r <= 1'b0;
        cnt_r <= '0;
      end else if (clkEn) begin
        s1_r  <= s1_nxt;
        s2_r  <= s2_nxt;
        out_r <= out_nxt;
        cnt_r <= cnt_nxt;
      end
    end
    assign port.cleanIn[i] = out_r;
  end
endmodule : ldd_input_filter
`default_nettype wire

// ==== ldd_input_decoder.sv ====
// Module: lift drive digital input decoder and motor temperature supervisor
// Operation
// - Overtemperature during travel lets travel finish.
// - Overtemperature at standstill blocks new travels.
// - Shorted PTC and linear sensor inputs raise error.
// - Sensor type PTC, linear, switch, off.
// - Eight inputs, functions chosen by preset.
// - Travel needs enable, speed and direction.
// - Standard presets: enable, speeds, up, down.
// - Presets 13/16, 30, 25 special mappings.
// - Preset 15 fixed binary speed code.
// - Braking unit type steers braking handling.
// - Preset 25 codes pick programmable speeds.
`default_nettype none
module ldd_input_decoder #(
  parameter int unsigned N_IN   = 8,
  parameter int unsigned DB_CYC = ldd_pkg::DEBOUNCE_CYC,
  parameter int unsigned RW     = 16
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  input  wire logic          clkEn,
  // Digital inputs
  input  wire logic [N_IN-1:0] digIn,
  // Configuration
  input  wire logic [7:0]    configPreset,
  input  wire logic [1:0]    motorTempSensorType,
  input  wire logic [RW-1:0] motorTempThreshold,
  input  wire logic [3:0]    freeBinaryPreset [1:7],
  input  wire logic [3:0]    brakingUnitType,
  input  wire logic [3:0]    brakingUnitRated,
  // Temperature sensor
  input  wire logic [RW-1:0] sensorOhm,
  input  wire logic          sensorSwitchOpen,
  // Braking
  input  wire logic [3:0]    brakingDemand,
  // Drive functions
  output logic               controllerEnable,
  output logic               directionUp,
  output logic               directionDown,
  output logic [3:0]         speedSelect,
  output logic               travelActive,
  output logic               motorOverTemp,
  output logic               sensorShortError,
  output logic               travelBlocked,
  output logic [3:0]         brakingLevel
);
  // Elaboration checks: the decode table is fixed at eight pins
  if (N_IN != 8) begin : g_badInputs
    $error("decoder serves exactly eight inputs");
  end
  if (RW < 12) begin : g_badWidth
    $error("resistance width too small");
  end
  // ----------------------------------------------------------------
  // Input filtering
  // ----------------------------------------------------------------
  ldd_filter_if #(.N(N_IN)) fif ();
  assign fif.rawIn = digIn;
  ldd_input_filter #(.N(N_IN), .CYC(DB_CYC)) u_filt (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clkEn   (clkEn),
    .port    (fif.filt)
  );
  logic [N_IN-1:0] in;
  assign in = fif.cleanIn;
  // ----------------------------------------------------------------
  // Preset decode
  // ----------------------------------------------------------------
  logic       enC, upC, dnC;
  logic [3:0] spdC;
  logic [2:0] code;
  always_comb begin
    enC  = 1'b0;
    upC  = 1'b0;
    dnC  = 1'b0;
    spdC = ldd_pkg::SPD_NONE;
    code = 3'h0;
    unique case (configPreset)
      ldd_pkg::CFG_FREE, ldd_pkg::CFG_P01, ldd_pkg::CFG_P03, ldd_pkg::CFG_P08,
      ldd_pkg::CFG_P11, ldd_pkg::CFG_P21, ldd_pkg::CFG_P13, ldd_pkg::CFG_P16: begin
        enC = in[0];
        upC = in[5];
        dnC = in[6];
        // Lowest-numbered input wins; input 8 only counts in 13/16, else free
        if (in[1]) spdC = ldd_pkg::SPD_ONE;
        else if (in[2]) spdC = ldd_pkg::SPD_TWO;
        else if (in[3]) spdC = ldd_pkg::SPD_THREE;
        else if (in[4]) spdC = ldd_pkg::SPD_INTER;
        else if (in[7] && (configPreset == ldd_pkg::CFG_P13 ||
                           configPreset == ldd_pkg::CFG_P16)) begin
          spdC = ldd_pkg::SPD_FOUR;
        end
      end
      ldd_pkg::CFG_P30: begin
        enC = in[0];
        upC = in[5];
        dnC = in[6];
        if (in[1]) spdC = ldd_pkg::SPD_ONE;
        else if (in[2]) spdC = ldd_pkg::SPD_FOUR;
        else if (in[3]) spdC = ldd_pkg::SPD_TWO;
        else if (in[4]) spdC = ldd_pkg::SPD_INTER;
        else if (in[7]) spdC = ldd_pkg::SPD_THREE;
      end
      ldd_pkg::CFG_P15: begin
        // Inputs 6 to 8 are free in this preset and never read
        enC  = in[0];
        upC  = in[1];
        dnC  = ~in[1];
        code = {in[4], in[3], in[2]};
        spdC = (code == 3'h7) ? ldd_pkg::SPD_INTER : {1'b0, code};
      end
      ldd_pkg::CFG_P25: begin
        // Inputs 6 and 7 are free in this preset and never read
        enC  = in[7];
        upC  = in[3];
        dnC  = in[4];
        code = {in[0], in[1], in[2]};
        spdC = (code == 3'h0) ? ldd_pkg::SPD_NONE : freeBinaryPreset[code];
      end
      default: begin
        spdC = ldd_pkg::SPD_NONE;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // Temperature supervision
  // ----------------------------------------------------------------
  logic otC, shortC;
  always_comb begin
    otC    = 1'b0;
    shortC = 1'b0;
    unique case (motorTempSensorType)
      ldd_pkg::SENS_OFF:    otC = 1'b0;
      ldd_pkg::SENS_PTC:    otC = sensorOhm >= RW'(ldd_pkg::PTC_TRIP_OHM);
      ldd_pkg::SENS_LINEAR: otC = sensorOhm >= motorTempThreshold;
      ldd_pkg::SENS_SWITCH: otC = sensorSwitchOpen;
    endcase
    // A switch has no resistance to judge, so only PTC and linear see shorts
    if (motorTempSensorType != ldd_pkg::SENS_OFF &&
        motorTempSensorType != ldd_pkg::SENS_SWITCH) begin
      shortC = sensorOhm < RW'(ldd_pkg::SHORT_LIMIT_OHM);
    end
  end
  // ----------------------------------------------------------------
  // Travel state machine
  // ----------------------------------------------------------------
  ldd_pkg::ldd_state_type st_r, st_nxt;
  logic request;
  // Direction conflict counts as no direction
  assign request = enC && (spdC != ldd_pkg::SPD_NONE) && (upC ^ dnC);
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ldd_pkg::ST_IDLE: begin
        if (otC || shortC) st_nxt = ldd_pkg::ST_LOCK;
        else if (request) st_nxt = ldd_pkg::ST_TRAVEL;
      end
      ldd_pkg::ST_TRAVEL: begin
        // Overtemperature ignored until the request drops
        if (!request) st_nxt = ldd_pkg::ST_IDLE;
      end
      ldd_pkg::ST_LOCK: begin
        if (!otC && !shortC) st_nxt = ldd_pkg::ST_IDLE;
      end
      default: st_nxt = ldd_pkg::ST_IDLE;
    endcase
  end
  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic [3:0] brk_nxt;
  always_comb begin
    // Demand capped at what the fitted unit can absorb; none fitted, none
    if (brakingUnitType == 4'h0) brk_nxt = 4'h0;
    else if (brakingDemand > brakingUnitRated) brk_nxt = brakingUnitRated;
    else brk_nxt = brakingDemand;
  end
  logic travelNxt;
  assign travelNxt = (st_nxt == ldd_pkg::ST_TRAVEL);
  // ----------------------------------------------------------------
  // Output next values
  // ----------------------------------------------------------------
  logic       dirUp_nxt, dirDown_nxt, blocked_nxt;
  logic [3:0] speed_nxt;
  always_comb begin
    // Conflicting directions show as none, so no output claims both
    dirUp_nxt   = upC && !dnC;
    dirDown_nxt = dnC && !upC;
    speed_nxt   = travelNxt ? spdC : ldd_pkg::SPD_NONE;
    blocked_nxt = (st_nxt == ldd_pkg::ST_LOCK);
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r             <= ldd_pkg::ST_IDLE;
      controllerEnable <= 1'b0;
      directionUp      <= 1'b0;
      directionDown    <= 1'b0;
      speedSelect      <= ldd_pkg::SPD_NONE;
      travelActive     <= 1'b0;
      motorOverTemp    <= 1'b0;
      sensorShortError <= 1'b0;
      travelBlocked    <= 1'b0;
      brakingLevel     <= 4'h0;
    end else if (clkEn) begin
      st_r             <= st_nxt;
      controllerEnable <= enC;
      directionUp      <= dirUp_nxt;
      directionDown    <= dirDown_nxt;
      speedSelect      <= speed_nxt;
      travelActive     <= travelNxt;
      motorOverTemp    <= otC;
      sensorShortError <= shortC;
      travelBlocked    <= blocked_nxt;
      brakingLevel     <= brk_nxt;
    end
  end
endmodule : ldd_input_decoder
`default_nettype wire

// ==== ldd_input_decoder_assertions.sv ====
// Checker: output relations of the lift drive input decoder
`default_nettype none
module ldd_input_decoder_assertions (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // Sensor and braking setup
  input wire logic [1:0]  motorTempSensorType,
  input wire logic [15:0] motorTempThreshold,
  input wire logic [15:0] sensorOhm,
  input wire logic        sensorSwitchOpen,
  input wire logic [3:0]  brakingUnitType,
  // Drive functions
  input wire logic        controllerEnable,
  input wire logic        directionUp,
  input wire logic        directionDown,
  input wire logic [3:0]  speedSelect,
  input wire logic        travelActive,
  input wire logic        motorOverTemp,
  input wire logic        sensorShortError,
  input wire logic        travelBlocked,
  input wire logic [3:0]  brakingLevel
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Sensor states
  // ----------------------------------------------------------------
  sequence s_short;
    motorTempSensorType inside {2'h1, 2'h2} && sensorOhm < 16'h0014;
  endsequence
  sequence s_ptcHot;
    motorTempSensorType == ldd_pkg::SENS_PTC && sensorOhm > 16'h0DAC;
  endsequence
  sequence s_linHot;
    motorTempSensorType == ldd_pkg::SENS_LINEAR && sensorOhm > motorTempThreshold
      && sensorOhm > 16'h0014;
  endsequence
  sequence s_swHot;
    motorTempSensorType == ldd_pkg::SENS_SWITCH && sensorSwitchOpen;
  endsequence
  sequence s_off;
    motorTempSensorType == ldd_pkg::SENS_OFF;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_START_NEEDS_ALL: assert property ($rose(travelActive) |-> controllerEnable
    && speedSelect != ldd_pkg::SPD_NONE && directionUp != directionDown)
    else $error("travel started without full request");
  AST_ONE_DIRECTION: assert property (!(directionUp && directionDown))
    else $error("both directions driven");
  AST_HOT_NO_ABORT: assert property ($fell(travelActive) |-> !travelBlocked
    && (!controllerEnable || speedSelect == ldd_pkg::SPD_NONE
    || directionUp == directionDown))
    else $error("travel ended with request present");
  AST_LOCK_REFUSES: assert property (travelBlocked && !travelActive |=> !travelActive)
    else $error("travel started while locked");
  AST_LOCK_CAUSE: assert property ($rose(travelBlocked) |-> motorOverTemp
    || sensorShortError || $past(motorOverTemp) || $past(sensorShortError))
    else $error("lock without temperature cause");
  AST_SHORT_FLAG: assert property (s_short ##1 s_short |-> sensorShortError)
    else $error("shorted sensor not flagged");
  AST_PTC_TRIP: assert property (s_ptcHot ##1 s_ptcHot |-> motorOverTemp)
    else $error("thermistor trip missed");
  AST_LINEAR_TRIP: assert property (s_linHot ##1 s_linHot |-> motorOverTemp)
    else $error("linear sensor trip missed");
  AST_SWITCH_TRIP: assert property (s_swHot ##1 s_swHot |-> motorOverTemp)
    else $error("thermal switch trip missed");
  AST_OFF_QUIET: assert property (s_off ##1 s_off |-> !motorOverTemp && !sensorShortError)
    else $error("flag raised with monitoring off");
  AST_NO_BRAKE_UNIT: assert property ((brakingUnitType == 4'h0) [*2] |-> brakingLevel == 4'h0)
    else $error("braking without unit fitted");
endmodule : ldd_input_decoder_assertions
bind ldd_input_decoder ldd_input_decoder_assertions u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .motorTempSensorType(motorTempSensorType), .motorTempThreshold(motorTempThreshold),
  .sensorOhm(sensorOhm), .sensorSwitchOpen(sensorSwitchOpen), .brakingUnitType(brakingUnitType),
  .controllerEnable(controllerEnable), .directionUp(directionUp), .directionDown(directionDown),
  .speedSelect(speedSelect), .travelActive(travelActive), .motorOverTemp(motorOverTemp),
  .sensorShortError(sensorShortError), .travelBlocked(travelBlocked),
  .brakingLevel(brakingLevel));
`default_nettype wire

// ==== ldd_lift_ctrl.sv ====
// Model: lift control system driving the parallel inputs
`default_nettype none
module ldd_lift_ctrl (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Request and pins
  input  wire logic [7:0] cmdIn,
  output logic [7:0]      digIn
);
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Pins move only after an edge, so all bits of a request land together
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      digIn <= 8'h00;
    end else begin
      digIn <= cmdIn;
    end
  end
endmodule : ldd_lift_ctrl
`default_nettype wire

// ==== ldd_input_decoder_tb.sv ====
// Testbench: scenarios for the lift drive input decoder
`default_nettype none
module ldd_input_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Stimulus and harness
  // ----------------------------------------------------------------
  localparam int unsigned SETTLE = 12;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  cmd = 8'h00;
  logic [7:0]  cfg = 8'h01;
  logic [1:0]  sType = 2'h0;
  logic [15:0] thr = 16'h07D0;
  logic [15:0] ohm = 16'h03E8;
  logic        swOpen = 1'b0;
  logic [3:0]  binTab [1:7];
  logic [3:0]  bType = 4'h0;
  logic [3:0]  bDemand = 4'h5;
  logic [3:0]  bRated = 4'hF;
  logic        run = 1'b1;
  logic [7:0]  digIn;
  logic        en, up, dn, act, hot, shortErr, blk;
  logic [3:0]  spd, brk;
  int          fails = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  ldd_lift_ctrl u_ctrl (.sys_clk(sys_clk), .rst_b(rst_b), .cmdIn(cmd), .digIn(digIn));
  // Short debounce keeps the run brief
  ldd_input_decoder #(.DB_CYC(4)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(run),
    .digIn(digIn), .configPreset(cfg), .motorTempSensorType(sType), .motorTempThreshold(thr),
    .freeBinaryPreset(binTab), .brakingUnitType(bType), .brakingUnitRated(bRated),
    .sensorOhm(ohm), .sensorSwitchOpen(swOpen), .brakingDemand(bDemand),
    .controllerEnable(en), .directionUp(up), .directionDown(dn), .speedSelect(spd),
    .travelActive(act), .motorOverTemp(hot), .sensorShortError(shortErr),
    .travelBlocked(blk), .brakingLevel(brk));
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic apply(input logic [7:0] d);
    @(posedge sys_clk);
    cmd <= d;
    repeat (SETTLE) @(posedge sys_clk);
    #1;
  endtask : apply
  task automatic sens(input logic [1:0] t, input logic [15:0] r, input logic s);
    @(posedge sys_clk);
    sType <= t;
    ohm <= r;
    swOpen <= s;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : sens
  task automatic t_map;
    logic [7:0] pr [9] = '{8'h00, 8'h01, 8'h03, 8'h08, 8'h11, 8'h21, 8'h13, 8'h16, 8'h30};
    logic [3:0] e [5];
    for (int p = 0; p < 9; p++) begin
      if (p == 8) e = '{4'h1, 4'h4, 4'h2, 4'h7, 4'h3};
      else e = '{4'h1, 4'h2, 4'h3, 4'h7, 4'h0};
      if (p == 6 || p == 7) e[4] = 4'h4;
      @(posedge sys_clk);
      cfg <= pr[p];
      for (int k = 0; k < 5; k++) begin
        apply(8'h21 | ((k < 4) ? (8'h02 << k) : 8'h80));
        chk(spd, e[k], "speed map");
        chk({en, up, act}, {2'b11, e[k] != 4'h0}, "travel map");
      end
    end
  endtask : t_map
  task automatic t_gate;
    @(posedge sys_clk);
    cfg <= 8'h01;
    apply(8'h22);
    chk(act, 1'b0, "no enable");
    apply(8'h21);
    chk(act, 1'b0, "no speed");
    apply(8'h63);
    chk({act, dn, up}, 3'b000, "both dirs");
    apply(8'h43);
    chk({act, dn, up}, 3'b110, "down");
    apply(8'h22);
    @(posedge sys_clk);
    cmd <= 8'h23;
    repeat (2) @(posedge sys_clk);
    cmd <= 8'h22;
    // Watched every cycle, so a pulse that slips through is seen
    repeat (SETTLE) begin
      @(posedge sys_clk);
      #1;
      chk({en, act}, 2'b00, "glitch");
    end
  endtask : t_gate
  task automatic t_bins;
    @(posedge sys_clk);
    cfg <= 8'h15;
    for (int c = 0; c < 8; c++) begin
      apply(8'h03 | 8'(c << 2));
      chk(spd, 4'(c), "fixed code");
      chk({act, up}, {c != 0, 1'b1}, "fixed travel");
    end
    apply(8'h1D);
    chk({act, dn}, 2'b11, "fixed down");
    @(posedge sys_clk);
    cfg <= 8'h25;
    for (int c = 0; c < 8; c++) begin
      apply(8'h88 | {5'h00, c[0], c[1], c[2]});
      chk(spd, (c == 0) ? 4'h0 : 4'(8 - c), "free code");
      chk(act, c != 0, "free travel");
    end
    apply(8'h91);
    chk({act, dn, up}, 3'b110, "free down");
  endtask : t_bins
  task automatic t_temp;
    @(posedge sys_clk);
    cfg <= 8'h01;
    apply(8'h23);
    sens(ldd_pkg::SENS_PTC, 16'h0FA0, 1'b0);
    chk({act, hot}, 2'b11, "hot in travel");
    apply(8'h00);
    chk(blk, 1'b1, "locked");
    apply(8'h23);
    chk(act, 1'b0, "start refused");
    sens(ldd_pkg::SENS_LINEAR, 16'h000A, 1'b0);
    chk(shortErr, 1'b1, "short");
    sens(ldd_pkg::SENS_LINEAR, 16'h09C4, 1'b0);
    chk({shortErr, hot}, 2'b01, "linear hot");
    sens(ldd_pkg::SENS_SWITCH, 16'h03E8, 1'b1);
    chk(hot, 1'b1, "switch open");
    sens(ldd_pkg::SENS_OFF, 16'h0FA0, 1'b1);
    chk(hot, 1'b0, "monitor off");
    sens(ldd_pkg::SENS_PTC, 16'h0BB8, 1'b0);
    apply(8'h00);
    chk({hot, blk}, 2'b00, "lock cleared");
    @(posedge sys_clk);
    bType <= 4'h0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(brk, 4'h0, "no unit");
    @(posedge sys_clk);
    bType <= 4'h1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(brk, 4'h5, "unit fitted");
    @(posedge sys_clk);
    bRated <= 4'h3;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(brk, 4'h3, "unit capped");
    @(posedge sys_clk);
    run <= 1'b0;
    bDemand <= 4'h1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(brk, 4'h3, "frozen");
    @(posedge sys_clk);
    run <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(brk, 4'h1, "resumed");
  endtask : t_temp
  task automatic end_of_test;
    $display("Counts: comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      $display("MISMATCH t=%0t run too long", $time);
      end_of_test();
    end
  end
  initial begin
    for (int i = 1; i < 8; i++) begin
      binTab[i] <= 4'(8 - i);
    end
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_map();
    t_gate();
    t_bins();
    t_temp();
    end_of_test();
  end
endmodule : ldd_input_decoder_tb
`default_nettype wire
